// *** rtl/iafp_pkg.sv ***
// Package: register map, fields, reset values and timing for the flash programmer
package iafp_pkg;
  // ==========================================================
  // Register indices (printed offsets are not word multiples)
  localparam logic [7:0] IDX_CHIP_CONTROL = 8'h9F;
  localparam logic [7:0] IDX_TRIGGER = 8'hA4;
  localparam logic [7:0] IDX_BLOCK_UPDATE_ENABLE = 8'hA5;
  localparam logic [7:0] IDX_FLASH_ADDR_LOW = 8'hA6;
  localparam logic [7:0] IDX_FLASH_ADDR_HIGH = 8'hA7;
  localparam logic [7:0] IDX_FLASH_DATA = 8'hAE;
  localparam logic [7:0] IDX_FLASH_COMMAND = 8'hAF;
  localparam logic [7:0] IDX_TIMED_ACCESS = 8'hC7;
  localparam logic [7:0] IDX_BROWNOUT_CONFIG = 8'hB0;
  localparam logic [7:0] IDX_BROWNOUT_CONTROL = 8'hB1;
  localparam logic [7:0] IDX_STATUS = 8'hB2;
  // ==========================================================
  // Field positions
  localparam int BIT_SELF_PROG_ENABLE = 0;
  localparam int BIT_FAULT_FLAG = 6;
  localparam int BIT_TRIGGER = 0;
  localparam int BIT_APP_UEN = 0;
  localparam int BIT_LDR_UEN = 1;
  localparam int BIT_CFG_UEN = 2;
  localparam int BIT_BROWNOUT_INHIBIT = 3;
  localparam int BIT_BOD_EN = 7;
  localparam int BIT_BOD_RST = 2;
  localparam int BIT_OP_ENABLE = 5;
  localparam int BIT_CTRL_ENABLE = 4;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_CHIP_CONTROL = 8'h00;
  localparam logic [7:0] RST_BLOCK_UPDATE = 8'h00;
  localparam logic [7:0] RST_FLASH_ADDR = 8'h00;
  localparam logic [7:0] RST_FLASH_DATA = 8'h00;
  localparam logic [7:0] RST_FLASH_COMMAND = 8'h30;
  localparam logic [7:0] RST_BROWNOUT_CONFIG = 8'hFF;
  localparam logic [7:0] RST_BROWNOUT_CONTROL = 8'h00;
  // ==========================================================
  // Commands, blocks and key
  localparam logic [3:0] FN_READ = 4'h0;
  localparam logic [3:0] FN_PROGRAM = 4'h1;
  localparam logic [3:0] FN_ERASE = 4'h2;
  localparam logic [1:0] BLK_APP = 2'h0;
  localparam logic [1:0] BLK_LDR = 2'h1;
  localparam logic [1:0] BLK_CFG = 2'h3;
  localparam logic [7:0] KEY_FIRST = 8'hAA;
  localparam logic [7:0] KEY_SECOND = 8'h55;
  localparam logic [15:0] FLASH_TOP_ADDR = 16'h47FF;
  localparam logic [15:0] CFG_TOP_ADDR = 16'h0004;
  localparam int TA_WINDOW_CYC = 4;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam real ERASE_TIME_MS = 5.0;
  localparam real PROGRAM_TIME_US = 23.5;
  localparam int ERASE_CYC = int'(ERASE_TIME_MS * CLK_HZ / 1000.0);
  localparam int PROGRAM_CYC = int'(PROGRAM_TIME_US * CLK_HZ / 1000000.0);
  localparam int READ_CYC = 2;
  localparam int RC_START_CYC = 4;
  localparam int CNT_W = 18;
endpackage

// *** rtl/iafp_flash_if.sv ***
// Interface: sequencer to flash array macro carrier
interface iafp_flash_if;
  logic req;
  logic [1:0] op;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic done;
  logic [7:0] rdata;
  modport seq (output req, op, addr, wdata, input done, rdata);
  modport arr (input req, op, addr, wdata, output done, rdata);
endinterface

// *** rtl/iafp_flash_array.sv ***
// Flash array model with timed erase and program
module iafp_flash_array
  import iafp_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int PROGRAM_CYCLES = PROGRAM_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Oscillator
  input wire logic osc_on,
  // Sequencer side
  iafp_flash_if.arr fl
);
  logic [7:0] mem [0:32767];
  logic [CNT_W-1:0] cnt_r;
  logic busy_r;
  logic done_r;
  logic [7:0] rdata_r;
  logic [15:0] page_r;
  logic erase_r;
  logic [7:0] erase_idx_r;

  assign fl.done = done_r;
  assign fl.rdata = rdata_r;

  // ==========================================================
  // Timer, paced by the aclk rate; a start needs the rc oscillator on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_r <= 1'b0;
      done_r <= 1'b0;
      cnt_r <= '0;
      rdata_r <= 8'h00;
      page_r <= 16'h0000;
      erase_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (!busy_r && fl.req && osc_on) begin
        busy_r <= 1'b1;
        page_r <= {fl.addr[15:7], 7'h00};
        erase_r <= (fl.op == 2'h2);
        unique case (fl.op)
          2'h2: cnt_r <= CNT_W'(ERASE_CYCLES);
          2'h1: cnt_r <= CNT_W'(PROGRAM_CYCLES);
          default: cnt_r <= CNT_W'(READ_CYC);
        endcase
        if (fl.op == 2'h0) begin
          rdata_r <= mem[fl.addr[14:0]];
        end
      end else if (busy_r) begin
        if (cnt_r <= CNT_W'(1)) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          erase_r <= 1'b0;
        end else begin
          cnt_r <= cnt_r - CNT_W'(1);
        end
      end
    end
  end

  // ==========================================================
  // Array writes; erase walks the page while the timer runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erase_idx_r <= 8'h00;
    end else if (!busy_r && fl.req && osc_on && fl.op == 2'h1) begin
      mem[fl.addr[14:0]] <= mem[fl.addr[14:0]] & fl.wdata;
    end else if (busy_r && erase_r && !erase_idx_r[7]) begin
      mem[{page_r[14:7], erase_idx_r[6:0]}] <= 8'hFF;
      erase_idx_r <= erase_idx_r + 8'h01;
    end else if (!busy_r) begin
      erase_idx_r <= 8'h00;
    end
  end
endmodule // iafp_flash_array

// *** rtl/iafp_top.sv ***
// Top: AXI4-Lite register file and self-programming sequencer
//
// Function
// - Enable bit gates function, key protected
// - Enabling starts internal rc oscillator timing
// - Per-block update enables gate erase/program
// - Setting trigger bit starts operation
// - Processor held until operation completes
// - Erase 5 ms, program 23.5 us internally
// - Trigger bit self-clears on completion
// - Bad address or command sets fault
// - Disabled block update sets fault
// - Brown-out inhibited update sets fault
// - Fault stays until software clears it
// - Config inhibit bit blocks low-supply update only with BOD enabled and BOD reset bit clear
// - Command register fields, reset 30h
// - Address formed from high and low
// - Function and block select decoding
// - Read result lands in data register
module iafp_top
  import iafp_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC,
  parameter int PROGRAM_CYCLES = PROGRAM_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Supply monitor pin
  input wire logic supply_below_bod,
  // Processor and oscillator
  output logic cpu_hold,
  output logic rc_osc_enable
);
  import iafp_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_RUN = 4'b0100,
    ST_DONE = 4'b1000
  } iafp_state_e;

  iafp_flash_if fl ();

  iafp_state_e state_r;
  logic [7:0] chip_control_r;
  logic [7:0] block_update_enable_r;
  logic [7:0] flash_addr_high_r;
  logic [7:0] flash_addr_low_r;
  logic [7:0] flash_data_byte_r;
  logic [7:0] flash_command_r;
  logic [7:0] brownout_config_byte_r;
  logic [7:0] brownout_control_r;
  logic trigger_bit_r;
  logic [1:0] ta_stage_r;
  logic [2:0] ta_cnt_r;
  logic [2:0] osc_cnt_r;
  logic bod_meta_r;
  logic bod_sync_r;
  logic req_r;
  logic [1:0] op_r;
  logic fault_set;
  logic bad_cmd;
  logic bad_addr;
  logic blk_locked;
  logic bod_block;
  logic is_update;
  logic ta_open;

  // AXI channel state
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_idx_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic [7:0] ar_idx;
  logic [7:0] rd_val;

  // ==========================================================
  // Supply comparator synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bod_meta_r <= 1'b0;
      bod_sync_r <= 1'b0;
    end else begin
      bod_meta_r <= supply_below_bod;
      bod_sync_r <= bod_meta_r;
    end
  end

  // ==========================================================
  // AXI write: address and data accepted in either order
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      aw_idx_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready;
      s_axi_wready <= !w_held_r && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
        aw_idx_r <= s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (rd_known(aw_idx_r)) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic rd_known(input logic [7:0] idx);
    rd_known = (idx == IDX_CHIP_CONTROL) || (idx == IDX_TRIGGER) ||
      (idx == IDX_BLOCK_UPDATE_ENABLE) || (idx == IDX_FLASH_ADDR_LOW) ||
      (idx == IDX_FLASH_ADDR_HIGH) || (idx == IDX_FLASH_DATA) ||
      (idx == IDX_FLASH_COMMAND) || (idx == IDX_TIMED_ACCESS) ||
      (idx == IDX_BROWNOUT_CONFIG) || (idx == IDX_BROWNOUT_CONTROL) ||
      (idx == IDX_STATUS);
  endfunction

  logic wr_lane;
  assign wr_lane = wr_go && wstrb_r[0];

  // ==========================================================
  // Timed access: key AA then 55 opens a short window
  assign ta_open = (ta_stage_r == 2'd2);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ta_stage_r <= 2'd0;
      ta_cnt_r <= 3'd0;
    end else if (wr_lane && aw_idx_r == IDX_TIMED_ACCESS) begin
      if (wdata_r[7:0] == KEY_FIRST) begin
        ta_stage_r <= 2'd1;
      end else if (wdata_r[7:0] == KEY_SECOND && ta_stage_r == 2'd1) begin
        ta_stage_r <= 2'd2;
        ta_cnt_r <= 3'(TA_WINDOW_CYC);
      end else begin
        ta_stage_r <= 2'd0;
      end
    end else if (wr_lane && ta_open) begin
      ta_stage_r <= 2'd0;
    end else if (ta_open) begin
      if (ta_cnt_r == 3'd0) begin
        ta_stage_r <= 2'd0;
      end else begin
        ta_cnt_r <= ta_cnt_r - 3'd1;
      end
    end
  end

  // ==========================================================
  // Setup registers; block update enable needs the key window
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_addr_high_r <= RST_FLASH_ADDR;
      flash_addr_low_r <= RST_FLASH_ADDR;
      flash_command_r <= RST_FLASH_COMMAND;
      brownout_config_byte_r <= RST_BROWNOUT_CONFIG;
      brownout_control_r <= RST_BROWNOUT_CONTROL;
      block_update_enable_r <= RST_BLOCK_UPDATE;
    end else if (wr_lane) begin
      unique case (aw_idx_r)
        IDX_FLASH_ADDR_HIGH: flash_addr_high_r <= wdata_r[7:0];
        IDX_FLASH_ADDR_LOW: flash_addr_low_r <= wdata_r[7:0];
        IDX_FLASH_COMMAND: flash_command_r <= wdata_r[7:0];
        IDX_BROWNOUT_CONFIG: brownout_config_byte_r <= wdata_r[7:0];
        IDX_BROWNOUT_CONTROL: brownout_control_r <= wdata_r[7:0];
        IDX_BLOCK_UPDATE_ENABLE: if (ta_open) block_update_enable_r <= {5'h00, wdata_r[2:0]};
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Chip control: enable is key protected, fault set beats clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chip_control_r <= RST_CHIP_CONTROL;
    end else begin
      if (wr_lane && aw_idx_r == IDX_CHIP_CONTROL && ta_open) begin
        chip_control_r[BIT_SELF_PROG_ENABLE] <= wdata_r[BIT_SELF_PROG_ENABLE];
        chip_control_r[BIT_FAULT_FLAG] <= wdata_r[BIT_FAULT_FLAG];
      end
      if (fault_set) begin
        chip_control_r[BIT_FAULT_FLAG] <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Data byte: software load or read result
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_data_byte_r <= RST_FLASH_DATA;
    end else if (state_r == ST_RUN && fl.done && op_r == 2'h0) begin
      flash_data_byte_r <= fl.rdata;
    end else if (wr_lane && aw_idx_r == IDX_FLASH_DATA) begin
      flash_data_byte_r <= wdata_r[7:0];
    end
  end

  // ==========================================================
  // Oscillator follows the enable bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rc_osc_enable <= 1'b0;
      osc_cnt_r <= 3'd0;
    end else begin
      rc_osc_enable <= chip_control_r[BIT_SELF_PROG_ENABLE];
      if (!rc_osc_enable) begin
        osc_cnt_r <= 3'd0;
      end else if (osc_cnt_r != 3'(RC_START_CYC)) begin
        osc_cnt_r <= osc_cnt_r + 3'd1;
      end
    end
  end

  // ==========================================================
  // Command checks
  always_comb begin
    is_update = flash_command_r[BIT_OP_ENABLE];
    bad_cmd = 1'b1;
    unique case (flash_command_r[3:0])
      FN_READ: bad_cmd = is_update || flash_command_r[BIT_CTRL_ENABLE];
      FN_PROGRAM, FN_ERASE: bad_cmd = !is_update || flash_command_r[BIT_CTRL_ENABLE];
      default: bad_cmd = 1'b1;
    endcase
    if (flash_command_r[7:6] == 2'h2) begin
      bad_cmd = 1'b1;
    end
    if (flash_command_r[7:6] == BLK_CFG) begin
      bad_addr = {flash_addr_high_r, flash_addr_low_r} > CFG_TOP_ADDR;
    end else begin
      bad_addr = {flash_addr_high_r, flash_addr_low_r} > FLASH_TOP_ADDR;
    end
    unique case (flash_command_r[7:6])
      BLK_APP: blk_locked = !block_update_enable_r[BIT_APP_UEN];
      BLK_LDR: blk_locked = !block_update_enable_r[BIT_LDR_UEN];
      default: blk_locked = !block_update_enable_r[BIT_CFG_UEN];
    endcase
    bod_block = brownout_control_r[BIT_BOD_EN] && !brownout_control_r[BIT_BOD_RST] &&
      brownout_config_byte_r[BIT_BROWNOUT_INHIBIT] && bod_sync_r;
  end

  assign fault_set = (state_r == ST_CHECK) &&
    (bad_cmd || bad_addr || (is_update && (blk_locked || bod_block)));

  // ==========================================================
  // Sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      trigger_bit_r <= 1'b0;
      cpu_hold <= 1'b0;
      req_r <= 1'b0;
      op_r <= 2'h0;
    end else begin
      req_r <= 1'b0;
      unique case (state_r)
        ST_IDLE: begin
          if (wr_lane && aw_idx_r == IDX_TRIGGER && ta_open && wdata_r[BIT_TRIGGER] &&
              chip_control_r[BIT_SELF_PROG_ENABLE] && osc_cnt_r == 3'(RC_START_CYC)) begin
            trigger_bit_r <= 1'b1;
            cpu_hold <= 1'b1;
            state_r <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          if (fault_set) begin
            state_r <= ST_DONE;
          end else begin
            op_r <= flash_command_r[1:0];
            req_r <= 1'b1;
            state_r <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (fl.done) begin
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          trigger_bit_r <= 1'b0;
          cpu_hold <= 1'b0;
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  assign fl.req = req_r;
  assign fl.op = op_r;
  assign fl.addr = {flash_addr_high_r, flash_addr_low_r};
  assign fl.wdata = flash_data_byte_r;

  iafp_flash_array #(
    .ERASE_CYCLES(ERASE_CYCLES),
    .PROGRAM_CYCLES(PROGRAM_CYCLES)
  ) u_array (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_on(rc_osc_enable),
    .fl(fl)
  );

  // ==========================================================
  // AXI read, one beat outstanding
  assign ar_idx = s_axi_araddr[9:2];

  always_comb begin
    unique case (ar_idx)
      IDX_CHIP_CONTROL: rd_val = chip_control_r;
      IDX_TRIGGER: rd_val = 8'h00;
      IDX_BLOCK_UPDATE_ENABLE: rd_val = block_update_enable_r;
      IDX_FLASH_ADDR_LOW: rd_val = flash_addr_low_r;
      IDX_FLASH_ADDR_HIGH: rd_val = flash_addr_high_r;
      IDX_FLASH_DATA: rd_val = flash_data_byte_r;
      IDX_FLASH_COMMAND: rd_val = flash_command_r;
      IDX_BROWNOUT_CONFIG: rd_val = brownout_config_byte_r;
      IDX_BROWNOUT_CONTROL: rd_val = brownout_control_r;
      IDX_STATUS: rd_val = {5'h00, bod_sync_r, trigger_bit_r, cpu_hold};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
        (!s_axi_rvalid && !s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_val};
        s_axi_rresp <= rd_known(ar_idx) ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // iafp_top

// *** dv/iafp_supply_model.sv ***
// Supply monitor model driving the brown-out level pin
module iafp_supply_model (
  // Clock
  input wire logic aclk,
  // Bench request
  input wire logic low_req,
  // Monitor pin
  output logic supply_below_bod
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Comparator output
  // Changes away from the edge, since the pin is asynchronous
  initial supply_below_bod = 1'b0;
  always @(posedge aclk) supply_below_bod <= #7 low_req;
endmodule // iafp_supply_model

// *** dv/iafp_top_properties.sv ***
// Port-level properties of the flash programmer top
module iafp_top_properties
  import iafp_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  // Processor and oscillator
  input wire logic cpu_hold,
  input wire logic rc_osc_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  int since_w;
  int hold_cnt;
  // ==========================================================
  // Helper counters
  always_ff @(posedge aclk) begin
    if (!aresetn) since_w <= 15;
    else if (s_axi_wvalid && s_axi_wready) since_w <= 0;
    else if (since_w < 15) since_w <= since_w + 1;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !cpu_hold) hold_cnt <= 0;
    else hold_cnt <= hold_cnt + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Properties
  property p_hold_needs_enable; $rose(cpu_hold) |-> rc_osc_enable; endproperty
  a_hold_needs_enable: assert property (p_hold_needs_enable) else $error("hold while disabled");
  property p_osc_settled; $rose(cpu_hold) |-> $past(rc_osc_enable, 3); endproperty
  a_osc_settled: assert property (p_osc_settled) else $error("hold before oscillator settled");
  property p_osc_during_hold; cpu_hold |-> rc_osc_enable; endproperty
  a_osc_during_hold: assert property (p_osc_during_hold) else $error("oscillator off in operation");
  property p_trigger_cause; $rose(cpu_hold) |-> since_w <= 4; endproperty
  a_trigger_cause: assert property (p_trigger_cause) else $error("hold without trigger write");
  property p_hold_min; $rose(cpu_hold) |=> cpu_hold; endproperty
  a_hold_min: assert property (p_hold_min) else $error("hold too short");
  property p_hold_bounded; cpu_hold |-> hold_cnt <= ERASE_CYCLES + 8; endproperty
  a_hold_bounded: assert property (p_hold_bounded) else $error("hold too long");
  property p_r_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_r_upper: assert property (p_r_upper) else $error("upper read bits set");
  property p_b_after_w; $rose(s_axi_bvalid) |-> since_w <= 2; endproperty
  a_b_after_w: assert property (p_b_after_w) else $error("write response without data");
  property p_rresp_code; s_axi_rvalid |-> s_axi_rresp inside {2'b00, 2'b10}; endproperty
  a_rresp_code: assert property (p_rresp_code) else $error("bad read response");
  c_hold_done: cover property ($fell(cpu_hold));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
  c_osc_off: cover property ($fell(rc_osc_enable));
endmodule // iafp_top_properties

bind iafp_top iafp_top_properties #(.ERASE_CYCLES(ERASE_CYCLES)) iafp_top_properties_inst (.aclk, .aresetn,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata, .s_axi_rresp, .cpu_hold, .rc_osc_enable);

// *** dv/testbench.sv ***
// Self-checking bench for the flash programmer top
module testbench import iafp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // Erase walks the whole page one byte a cycle, so it needs at least 128
  localparam int ERA = 200;
  localparam int PRG = 10;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, got;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bready = 1, low_req = 0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, supply_below_bod, cpu_hold;
  logic rc_osc_enable, ff_m = 0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] lfsr_r = 16'hA637, a;
  logic [7:0] mem_m [int];
  logic [7:0] uen_m = 8'h00, bodc_m = 8'h00, cfg_m = 8'hFF;
  logic [7:0] tab_i [7] = '{8'h9F, 8'hA5, 8'hA6, 8'hA7, 8'hAE, 8'hAF, 8'hB0};
  logic [7:0] tab_v [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'hFF};
  logic [7:0] bad_c [6] = '{8'h0F, 8'h11, 8'h80, 8'h20, 8'h05, 8'h01};
  int n_mismatch = 0, total_checks = 0, hold_cycles = 0;
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) if (cpu_hold === 1'b1) hold_cycles <= hold_cycles + 1;
  iafp_top #(.ERASE_CYCLES(ERA), .PROGRAM_CYCLES(PRG)) iafp_top_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .supply_below_bod, .cpu_hold, .rc_osc_enable);
  iafp_supply_model iafp_supply_model_inst (.aclk, .low_req, .supply_below_bod);
  // ==========================================================
  // Helpers
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] rdm(input logic [15:0] x);
    return mem_m.exists(x) ? mem_m[x] : 8'hFF;
  endfunction
  function automatic logic mdl_fault(input logic [7:0] c, input logic [15:0] x);
    logic upd;
    upd = c[3:0] != FN_READ;
    return c[4] || c[7:6] == 2'b10 || c[3:0] > FN_ERASE || (!upd && c[5]) || (upd && !c[5]) ||
      x > (c[7:6] == BLK_CFG ? CFG_TOP_ADDR : FLASH_TOP_ADDR) ||
      (upd && !uen_m[(c[7:6] == BLK_CFG) ? 2 : int'(c[7:6])]) ||
      (upd && low_req && bodc_m[BIT_BOD_EN] && !bodc_m[BIT_BOD_RST] && cfg_m[BIT_BROWNOUT_INHIBIT]);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // Bus cycles
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic aw_ok, w_ok;
    aw_ok = 0;
    w_ok = 0;
    s_axi_awaddr <= {22'h0, idx, 2'b00};
    s_axi_wdata <= {lfsr_r, 8'h00, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) begin
        aw_ok = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1) begin
        w_ok = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw_ok && w_ok));
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] idx);
    s_axi_araddr <= {22'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic kw(input logic [7:0] idx, input logic [7:0] d);
    wr(IDX_TIMED_ACCESS, KEY_FIRST);
    wr(IDX_TIMED_ACCESS, KEY_SECOND);
    wr(idx, d);
  endtask
  // One flash operation, checked against the model
  task automatic op(input logic [7:0] c, input logic [15:0] x, input logic [7:0] d, input logic clr);
    logic f;
    int mn;
    f = mdl_fault(c, x);
    mn = f ? 1 : c[3:0] == FN_ERASE ? ERA : c[3:0] == FN_PROGRAM ? PRG : 1;
    wr(IDX_FLASH_ADDR_HIGH, x[15:8]);
    wr(IDX_FLASH_ADDR_LOW, x[7:0]);
    wr(IDX_FLASH_DATA, d);
    wr(IDX_FLASH_COMMAND, c);
    hold_cycles = 0;
    kw(IDX_TRIGGER, 8'h01);
    do @(posedge aclk); while (cpu_hold === 1'b1);
    chk(32'(hold_cycles >= mn && hold_cycles <= mn + 8), 32'h1);
    if (!f && c[7:6] == BLK_APP && c[3:0] == FN_ERASE) for (int i = 0; i < 128; i++) mem_m[{x[15:7], 7'h0} + i] = 8'hFF;
    if (!f && c[7:6] == BLK_APP && c[3:0] == FN_PROGRAM) mem_m[x] = rdm(x) & d;
    ff_m = ff_m | f;
    rd(IDX_CHIP_CONTROL);
    chk(got & 32'h41, {25'h0, ff_m, 6'h01});
    rd(IDX_TRIGGER);
    chk(got, 32'h0);
    rd(IDX_STATUS);
    chk(got & 32'h3, 32'h0);
    if (!f && c == 8'h00) begin
      rd(IDX_FLASH_DATA);
      chk(got, {24'h0, rdm(x)});
    end
    if (clr) begin
      kw(IDX_CHIP_CONTROL, 8'h01);
      ff_m = 0;
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++) begin
      rd(tab_i[i]);
      chk(got, {24'h0, tab_v[i]});
    end
    rd(8'h10);
    chk(32'(resp), 32'h2);
    wr(8'h10, 8'h00);
    chk(32'(resp), 32'h2);
    wr(IDX_CHIP_CONTROL, 8'h01);
    rd(IDX_CHIP_CONTROL);
    chk({got[0], rc_osc_enable}, 32'h0);
    kw(IDX_CHIP_CONTROL, 8'h01);
    rd(IDX_CHIP_CONTROL);
    chk({got[0], rc_osc_enable}, 32'h3);
    wr(IDX_FLASH_COMMAND, 8'hD5);
    rd(IDX_FLASH_COMMAND);
    chk(got, 32'hD5);
    foreach (tab_v[i]) if (i < 3) op({(i == 2) ? BLK_CFG : 2'(i), 6'h22}, 16'h0, 8'h0, 1);
    kw(IDX_BLOCK_UPDATE_ENABLE, 8'h07);
    uen_m = 8'h07;
    for (int k = 0; k < 2; k++) begin
      a = {2'b00, lfsr_r[13:0]};
      lfsr_r = lfsr_next(lfsr_r);
      op(8'h22, a, 8'h00, 1);
      op(8'h21, a, lfsr_r[7:0], 1);
      op(8'h21, a, lfsr_r[15:8], 1);
      op(8'h00, a, 8'h00, 1);
      lfsr_r = lfsr_next(lfsr_r);
    end
    foreach (bad_c[i]) op(bad_c[i], 16'h0, 8'h0, 1);
    op(8'h00, 16'h4800, 8'h0, 1);
    op(8'hC0, 16'h0005, 8'h0, 1);
    op(8'h0F, 16'h0, 8'h0, 0);
    op(8'h00, a, 8'h0, 1);
    low_req <= 1'b1;
    wr(IDX_BROWNOUT_CONTROL, 8'h80);
    bodc_m = 8'h80;
    op(8'h21, a, 8'h00, 1);
    op(8'h00, a, 8'h0, 1);
    wr(IDX_BROWNOUT_CONFIG, 8'hF7);
    cfg_m = 8'hF7;
    op(8'h21, a, 8'hFF, 1);
    low_req <= 1'b0;
    kw(IDX_CHIP_CONTROL, 8'h00);
    rd(IDX_CHIP_CONTROL);
    chk({got[0], rc_osc_enable}, 32'h0);
    report_and_stop;
  end
  // Hang guard, well past the expected run length
  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    report_and_stop;
  end
endmodule // testbench
